// ==== common/audio_clock_pkg.sv ====
// constants, register layouts and field types of the audio clock generator
// assumes: one 100 MHz system clock, registers reached over a plain strobe port
// ****************************************************************
// Overview of operation
// - source select bit 13: one gives undivided clock, zero gives integer-divided clock
// - PCM clock runs only while enable bit 12 is set, else held stopped
// - PCM divisor is 12 bits at 11:0, served as two when programmed below two
// - fraction field: leftmost one sets denominator, count of ones sets numerator
// - fraction bits applied from leading one downward, 0x0110 gives two in nine
// - PDM clock divided by bits 7:0, output only while enable bit 8 and master select bit 9 are set
// - second converter clock runs only while enable bit 17 is set
// - first converter clock enable bit 16, divisors at 7:0 and 15:8
// ****************************************************************
package audio_clock_pkg;
   // register byte addresses
   localparam logic [31:0] PCM_DIV_ADDR = 32'h5003_0040;
   localparam logic [31:0] PCM_FRAC_ADDR = 32'h5003_0044;
   localparam logic [31:0] PDM_ADDR = 32'h5003_0048;
   localparam logic [31:0] CONV_ADDR = 32'h5003_004c;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   // divider widths and the smallest usable PCM divisor
   localparam int PCM_DIV_W = 12;
   localparam int SMALL_DIV_W = 8;
   localparam int FRAC_W = 16;
   localparam logic [11:0] PCM_DIV_MIN = 12'h002;
   localparam logic [7:0] SMALL_DIV_MIN = 8'h01;

   // field layouts, msb first, reserved bits read zero
   typedef struct packed {
      logic [17:0] reserved;
      logic pcm_source_select;
      logic pcm_clock_enable;
      logic [11:0] pcm_divisor;
   } pcm_div_s;

   typedef struct packed {
      logic [15:0] reserved;
      logic [15:0] pcm_fraction_pattern;
   } pcm_frac_s;

   typedef struct packed {
      logic [21:0] reserved;
      logic pdm_clock_master_select;
      logic pdm_clock_enable;
      logic [7:0] pdm_divisor;
   } pdm_ctrl_s;

   typedef struct packed {
      logic [13:0] reserved;
      logic second_converter_clock_enable;
      logic first_converter_clock_enable;
      logic [7:0] second_converter_divisor;
      logic [7:0] first_converter_divisor;
   } conv_ctrl_s;

   // writable bits of each register
   localparam logic [31:0] PCM_DIV_MASK = 32'h0000_3fff;
   localparam logic [31:0] PCM_FRAC_MASK = 32'h0000_ffff;
   localparam logic [31:0] PDM_MASK = 32'h0000_03ff;
   localparam logic [31:0] CONV_MASK = 32'h0003_ffff;

   // index of the three small dividers
   localparam int SMALL_COUNT = 3;
   localparam int IDX_PDM = 0;
   localparam int IDX_CONV1 = 1;
   localparam int IDX_CONV2 = 2;
endpackage

// ==== rtl/audio_clock_gen.sv ====
// audio clock generator: PCM, PDM and two rate converter clock enables
// assumes: software holds the divisor ordering, strobes are single cycle
`timescale 1ns/1ps
module audio_clock_gen #(
   parameter int ADDR_W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [31:0] rd_data,
   output logic pcm_clock_pulse,
   output logic pdm_clock_pulse,
   output logic pdm_master,
   output logic first_converter_pulse,
   output logic second_converter_pulse
);
   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   if (ADDR_W != 32) begin : g_bad_addr
      $error("address must be 32 bits wide");
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   audio_clock_pkg::pcm_div_s pcm_div, next_pcm_div;
   audio_clock_pkg::pcm_frac_s pcm_frac, next_pcm_frac;
   audio_clock_pkg::pdm_ctrl_s pdm_ctrl, next_pdm_ctrl;
   audio_clock_pkg::conv_ctrl_s conv_ctrl, next_conv_ctrl;
   logic [31:0] next_rd_data;
   logic pcm_written;

   // software writes land whole; divisor ordering is left to software
   always_comb begin
      next_pcm_div = pcm_div;
      next_pcm_frac = pcm_frac;
      next_pdm_ctrl = pdm_ctrl;
      next_conv_ctrl = conv_ctrl;
      next_rd_data = 32'h0000_0000;
      if (wr_strobe && addr == audio_clock_pkg::PCM_DIV_ADDR) begin
         next_pcm_div = wr_data & audio_clock_pkg::PCM_DIV_MASK;
      end else if (wr_strobe && addr == audio_clock_pkg::PCM_FRAC_ADDR) begin
         next_pcm_frac = wr_data & audio_clock_pkg::PCM_FRAC_MASK;
      end else if (wr_strobe && addr == audio_clock_pkg::PDM_ADDR) begin
         next_pdm_ctrl = wr_data & audio_clock_pkg::PDM_MASK;
      end else if (wr_strobe && addr == audio_clock_pkg::CONV_ADDR) begin
         next_conv_ctrl = wr_data & audio_clock_pkg::CONV_MASK;
      end
      // unmapped reads answer zero
      if (rd_strobe && addr == audio_clock_pkg::PCM_DIV_ADDR) begin
         next_rd_data = pcm_div;
      end else if (rd_strobe && addr == audio_clock_pkg::PCM_FRAC_ADDR) begin
         next_rd_data = pcm_frac;
      end else if (rd_strobe && addr == audio_clock_pkg::PDM_ADDR) begin
         next_rd_data = pdm_ctrl;
      end else if (rd_strobe && addr == audio_clock_pkg::CONV_ADDR) begin
         next_rd_data = conv_ctrl;
      end
   end

   assign pcm_written = wr_strobe && (addr == audio_clock_pkg::PCM_DIV_ADDR ||
      addr == audio_clock_pkg::PCM_FRAC_ADDR);

   // all fields clear so every clock starts stopped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pcm_div <= audio_clock_pkg::RESET_VALUE;
         pcm_frac <= audio_clock_pkg::RESET_VALUE;
         pdm_ctrl <= audio_clock_pkg::RESET_VALUE;
         conv_ctrl <= audio_clock_pkg::RESET_VALUE;
         rd_data <= 32'h0000_0000;
      end else begin
         pcm_div <= next_pcm_div;
         pcm_frac <= next_pcm_frac;
         pdm_ctrl <= next_pdm_ctrl;
         conv_ctrl <= next_conv_ctrl;
         rd_data <= next_rd_data;
      end
   end

   // ****************************************************************
   // PCM divider with fractional stretch
   // ****************************************************************
   localparam int PCM_DIV_W_L = audio_clock_pkg::PCM_DIV_W + 1;
   logic [PCM_DIV_W_L-1:0] pcm_cnt, next_pcm_cnt;
   logic [3:0] frac_idx, next_frac_idx;
   logic [3:0] frac_lead;
   logic [3:0] next_frac_lead;
   logic [PCM_DIV_W_L-1:0] pcm_period;
   logic [11:0] pcm_div_eff;
   logic frac_extra;
   logic next_pcm_pulse;

   // leading one of the pattern fixes the denominator
   // the lead of the incoming pattern restarts the walk, so a fresh write is never stale
   always_comb begin
      frac_lead = 4'h0;
      next_frac_lead = 4'h0;
      for (int i = 0; i < audio_clock_pkg::FRAC_W; i++) begin
         if (pcm_frac.pcm_fraction_pattern[i]) begin
            frac_lead = 4'(i);
         end
         if (next_pcm_frac.pcm_fraction_pattern[i]) begin
            next_frac_lead = 4'(i);
         end
      end
   end

   // a divisor under the minimum is served as the minimum
   assign pcm_div_eff = (pcm_div.pcm_divisor < audio_clock_pkg::PCM_DIV_MIN) ?
      audio_clock_pkg::PCM_DIV_MIN : pcm_div.pcm_divisor;
   // each one bit in the walk stretches one period by a cycle
   assign frac_extra = pcm_frac.pcm_fraction_pattern[frac_idx];
   assign pcm_period = {1'b0, pcm_div_eff} + {12'h000, frac_extra};

   always_comb begin
      next_pcm_cnt = pcm_cnt;
      next_frac_idx = frac_idx;
      next_pcm_pulse = 1'b0;
      if (!pcm_div.pcm_clock_enable || pcm_written) begin
         // stopped clock, and a restart of the walk after any reprogramming
         next_pcm_cnt = '0;
         next_frac_idx = next_frac_lead;
      end else if (pcm_div.pcm_source_select) begin
         next_pcm_pulse = 1'b1; // undivided clock
         next_pcm_cnt = '0;
      end else if (pcm_cnt >= pcm_period - 13'h0001) begin
         next_pcm_pulse = 1'b1; // integer-divided clock
         next_pcm_cnt = '0;
         // walk from the leading one down, then wrap
         next_frac_idx = (frac_idx == 4'h0 || frac_idx > frac_lead) ? frac_lead :
            frac_idx - 4'h1;
      end else begin
         next_pcm_cnt = pcm_cnt + 13'h0001;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pcm_cnt <= '0;
         frac_idx <= 4'h0;
         pcm_clock_pulse <= 1'b0;
      end else begin
         pcm_cnt <= next_pcm_cnt;
         frac_idx <= next_frac_idx;
         pcm_clock_pulse <= next_pcm_pulse;
      end
   end

   // ****************************************************************
   // PDM and rate converter dividers
   // ****************************************************************
   localparam int SW = audio_clock_pkg::SMALL_DIV_W;
   localparam int SC = audio_clock_pkg::SMALL_COUNT;
   logic [SC-1:0] small_run;
   logic [SW-1:0] small_div [SC];
   logic [SW-1:0] small_cnt [SC];
   logic [SW-1:0] next_small_cnt [SC];
   logic [SC-1:0] small_pulse, next_small_pulse;
   logic next_pdm_master;

   // PDM clock is made here only in master mode
   assign small_run[audio_clock_pkg::IDX_PDM] = pdm_ctrl.pdm_clock_enable &&
      pdm_ctrl.pdm_clock_master_select;
   assign small_div[audio_clock_pkg::IDX_PDM] = pdm_ctrl.pdm_divisor;
   assign small_run[audio_clock_pkg::IDX_CONV1] = conv_ctrl.first_converter_clock_enable;
   assign small_div[audio_clock_pkg::IDX_CONV1] = conv_ctrl.first_converter_divisor;
   assign small_run[audio_clock_pkg::IDX_CONV2] = conv_ctrl.second_converter_clock_enable;
   assign small_div[audio_clock_pkg::IDX_CONV2] = conv_ctrl.second_converter_divisor;
   assign next_pdm_master = pdm_ctrl.pdm_clock_master_select;

   for (genvar g = 0; g < SC; g++) begin : g_small
      logic [SW-1:0] div_eff;
      // zero divides as one, so a cleared divisor cannot hang the count
      assign div_eff = (small_div[g] < audio_clock_pkg::SMALL_DIV_MIN) ?
         audio_clock_pkg::SMALL_DIV_MIN : small_div[g];

      always_comb begin
         next_small_cnt[g] = '0;
         next_small_pulse[g] = 1'b0;
         if (small_run[g]) begin
            if (small_cnt[g] >= div_eff - 8'h01) begin
               next_small_pulse[g] = 1'b1;
            end else begin
               next_small_cnt[g] = small_cnt[g] + 8'h01;
            end
         end
      end

      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            small_cnt[g] <= '0;
            small_pulse[g] <= 1'b0;
         end else begin
            small_cnt[g] <= next_small_cnt[g];
            small_pulse[g] <= next_small_pulse[g];
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pdm_master <= 1'b0;
      end else begin
         pdm_master <= next_pdm_master;
      end
   end

   assign pdm_clock_pulse = small_pulse[audio_clock_pkg::IDX_PDM];
   assign first_converter_pulse = small_pulse[audio_clock_pkg::IDX_CONV1];
   assign second_converter_pulse = small_pulse[audio_clock_pkg::IDX_CONV2];

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [12:0] pcm_gap;
   logic pcm_settled;

   // cycles since the last PCM pulse, and whether the config held since then
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pcm_gap <= 13'h0001;
         pcm_settled <= 1'b0;
      end else begin
         pcm_gap <= pcm_clock_pulse ? 13'h0001 : pcm_gap + 13'h0001;
         if (pcm_written || !pcm_div.pcm_clock_enable || pcm_div.pcm_source_select) begin
            pcm_settled <= 1'b0;
         end else if (pcm_clock_pulse) begin
            pcm_settled <= 1'b1;
         end
      end
   end

   sequence s_pcm_undivided;
      pcm_div.pcm_clock_enable && pcm_div.pcm_source_select && !pcm_written;
   endsequence

   sequence s_pcm_divided_pulse;
      pcm_clock_pulse && pcm_div.pcm_clock_enable && !pcm_div.pcm_source_select;
   endsequence

   AST_PCM_UNDIVIDED: assert property (@(posedge clk) disable iff (reset)
      s_pcm_undivided |=> pcm_clock_pulse)
      else $error("undivided PCM clock missed a cycle");

   AST_PCM_STOPPED: assert property (@(posedge clk) disable iff (reset)
      !pcm_div.pcm_clock_enable |=> !pcm_clock_pulse)
      else $error("PCM clock ran while disabled");

   AST_PCM_MIN_GAP: assert property (@(posedge clk) disable iff (reset)
      s_pcm_divided_pulse ##1 !pcm_written |-> !pcm_clock_pulse)
      else $error("divided PCM pulses back to back");

   AST_PCM_FRAC_PERIOD: assert property (@(posedge clk) disable iff (reset)
      pcm_clock_pulse && pcm_settled && !$past(pcm_written) |->
      (pcm_gap == {1'b0, pcm_div_eff} || pcm_gap == {1'b0, pcm_div_eff} + 13'h0001))
      else $error("PCM period outside divisor plus fraction");

   AST_FRAC_LEAD: assert property (@(posedge clk) disable iff (reset)
      pcm_written |=> frac_idx == frac_lead)
      else $error("fraction walk did not restart at leading one");

   AST_PDM_STOPPED: assert property (@(posedge clk) disable iff (reset)
      !(pdm_ctrl.pdm_clock_enable && pdm_ctrl.pdm_clock_master_select) |=> !pdm_clock_pulse)
      else $error("PDM clock ran while off or in slave mode");

   AST_PDM_MODE: assert property (@(posedge clk) disable iff (reset)
      1'b1 |=> pdm_master == $past(pdm_ctrl.pdm_clock_master_select))
      else $error("PDM mode output does not follow its bit");

   AST_CONV2_STOPPED: assert property (@(posedge clk) disable iff (reset)
      !conv_ctrl.second_converter_clock_enable |=> !second_converter_pulse)
      else $error("second converter clock ran while disabled");

   AST_CONV1_STOPPED: assert property (@(posedge clk) disable iff (reset)
      !conv_ctrl.first_converter_clock_enable |=> !first_converter_pulse)
      else $error("first converter clock ran while disabled");

   AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> (pcm_div == '0 && pdm_ctrl == '0 && conv_ctrl == '0 &&
      !pcm_clock_pulse && !pdm_clock_pulse))
      else $error("fields not clear after reset");
endmodule

// ==== bench/audio_clock_sink.sv ====
// far-side model: a consumer of one audio clock enable pulse
// assumes: pulses are one-cycle enables on the system clock
`timescale 1ns/1ps
module audio_clock_sink (
   input wire logic clk,
   input wire logic reset,
   input wire logic clear,
   input wire logic pulse,
   output logic [15:0] pulses,
   output logic [15:0] span
);
   // ****************************************************************
   // period bookkeeping
   // ****************************************************************
   logic [15:0] since;
   logic [15:0] next_pulses, next_span, next_since;

   // span sums the gaps after the first pulse, so a phase offset never counts
   always_comb begin
      next_pulses = pulses;
      next_span = span;
      next_since = since + 16'h0001;
      if (clear) begin
         next_pulses = 16'h0000;
         next_span = 16'h0000;
      end else if (pulse) begin
         next_pulses = pulses + 16'h0001;
         next_since = 16'h0001;
         if (pulses != 16'h0000) begin
            next_span = span + since;
         end
      end
   end

   // registers only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulses <= 16'h0000;
         span <= 16'h0000;
         since <= 16'h0000;
      end else begin
         pulses <= next_pulses;
         span <= next_span;
         since <= next_since;
      end
   end
endmodule

// ==== bench/audio_clock_gen_tb.sv ====
// self-checking bench of the audio clock generator
// assumes: register port without wait states, four pulse sinks at the far side
`timescale 1ns/1ps
module audio_clock_gen_tb;
   logic clk, reset, wr_strobe, rd_strobe, clear;
   logic [31:0] addr, wr_data, rd_data, d;
   logic pcm_clock_pulse, pdm_clock_pulse, pdm_master;
   logic first_converter_pulse, second_converter_pulse;
   logic [3:0] pulse_bus;
   wire [3:0][15:0] pulses, span;
   int n_fail, check_count;
   localparam logic [31:0] REGS [4] = '{audio_clock_pkg::PCM_DIV_ADDR,
      audio_clock_pkg::PCM_FRAC_ADDR, audio_clock_pkg::PDM_ADDR, audio_clock_pkg::CONV_ADDR};
   localparam logic [31:0] MASKS [4] = '{audio_clock_pkg::PCM_DIV_MASK,
      audio_clock_pkg::PCM_FRAC_MASK, audio_clock_pkg::PDM_MASK, audio_clock_pkg::CONV_MASK};

   // ****************************************************************
   // design and far side
   // ****************************************************************
   audio_clock_gen audio_clock_gen_i (.clk(clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .pcm_clock_pulse(pcm_clock_pulse), .pdm_clock_pulse(pdm_clock_pulse),
      .pdm_master(pdm_master), .first_converter_pulse(first_converter_pulse),
      .second_converter_pulse(second_converter_pulse));
   assign pulse_bus = {second_converter_pulse, first_converter_pulse, pdm_clock_pulse,
      pcm_clock_pulse};
   for (genvar k = 0; k < 4; k++) begin : sink_g
      audio_clock_sink audio_clock_sink_i (.clk(clk), .reset(reset), .clear(clear),
         .pulse(pulse_bus[k]), .pulses(pulses[k]), .span(span[k]));
   end

   // clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1 v = rd_data;
   endtask

   // restart the sinks, run, then compare period and count
   task automatic measure(input int k, input int cyc, input logic [31:0] per,
      input logic [31:0] least);
      @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      repeat (cyc) @(posedge clk);
      #1;
      check({16'h0000, span[k]}, ({16'h0000, pulses[k]} - 32'h1) * per);
      check(32'({16'h0000, pulses[k]} >= least), 32'h1);
   endtask

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_reset;
      foreach (REGS[i]) begin
         rd(REGS[i], d);
         check(d, audio_clock_pkg::RESET_VALUE);
      end
      check({27'h0, pulse_bus, pdm_master}, 32'h0);
      $display("test reset done");
   endtask

   // all-ones write lands only on the documented fields; a stray address stays dead
   task automatic test_regs;
      foreach (REGS[i]) begin
         wr(REGS[i], 32'hffff_ffff);
         rd(REGS[i], d);
         check(d, MASKS[i]);
      end
      wr(32'h5003_0050, 32'hffff_ffff);
      rd(32'h5003_0050, d);
      check(d, 32'h0);
      foreach (REGS[i]) wr(REGS[i], 32'h0);
      $display("test regs done");
   endtask

   task automatic test_pcm;
      wr(REGS[0], 32'h0000_3005);
      measure(0, 20, 32'h1, 32'h12);
      wr(REGS[0], 32'h0000_1005);
      measure(0, 40, 32'h5, 32'h6);
      wr(REGS[0], 32'h0000_1003);
      measure(0, 30, 32'h3, 32'h8);
      wr(REGS[0], 32'h0000_1001);
      measure(0, 20, 32'h2, 32'h8);
      wr(REGS[0], 32'h0000_0003);
      measure(0, 20, 32'h0, 32'h0);
      check({16'h0, pulses[0]}, 32'h0);
      $display("test pcm done");
   endtask

   // fraction: any run of one full pattern adds one cycle per set bit
   task automatic test_frac;
      logic [31:0] pat [2] = '{32'h0110, 32'hfeee};
      logic [31:0] den [2] = '{32'h9, 32'h10};
      logic [31:0] ones [2] = '{32'h2, 32'hd};
      int n;
      foreach (pat[i]) begin
         wr(REGS[1], pat[i]);
         wr(REGS[0], 32'h0000_1002);
         @(posedge clk);
         clear <= 1'b1;
         @(posedge clk);
         clear <= 1'b0;
         n = 0;
         while ({16'h0, pulses[0]} < den[i] + 32'h1 && n < 200) begin
            @(posedge clk);
            #1 n++;
         end
         if (n >= 200) begin
            n_fail++;
            stop_test();
         end
         check({16'h0, span[0]}, den[i] * 32'h2 + ones[i]);
      end
      wr(REGS[0], 32'h0);
      wr(REGS[1], 32'h0);
      $display("test frac done");
   endtask

   task automatic test_pdm;
      wr(REGS[2], 32'h0000_0304);
      measure(1, 40, 32'h4, 32'h9);
      check({31'h0, pdm_master}, 32'h1);
      wr(REGS[2], 32'h0000_0104);
      measure(1, 20, 32'h0, 32'h0);
      check({15'h0, pdm_master, pulses[1]}, 32'h0);
      wr(REGS[2], 32'h0000_0204);
      measure(1, 20, 32'h0, 32'h0);
      check({16'h0, pulses[1]}, 32'h0);
      $display("test pdm done");
   endtask

   task automatic test_conv;
      wr(REGS[3], 32'h0003_0502);
      measure(2, 30, 32'h2, 32'he);
      measure(3, 30, 32'h5, 32'h5);
      wr(REGS[3], 32'h0002_0502);
      measure(2, 20, 32'h0, 32'h0);
      check({16'h0, pulses[2]}, 32'h0);
      wr(REGS[3], 32'h0000_0502);
      measure(3, 20, 32'h0, 32'h0);
      check({16'h0, pulses[3]}, 32'h0);
      $display("test conv done");
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      reset = 1'b1;
      wr_strobe = 1'b0;
      rd_strobe = 1'b0;
      clear = 1'b0;
      addr = 32'h0;
      wr_data = 32'h0;
      n_fail = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      test_reset();
      test_regs();
      test_pcm();
      test_frac();
      test_pdm();
      test_conv();
      stop_test();
   end
endmodule
